// [ehap_core.v]
// emulation halt and access logic: halt entry/exit, internal access bus, pin floating
`timescale 1ns/10ps
`include "ehap_map.vh"
// Overview of operation
// - halted: clocks stop, I/O pins freeze, oscillator runs
// - halt preserves special registers, counter, scratchpad
// - select low: data bus, address, strobes access
// - address high bit0 picks registers or scratchpad
// - advanced-only registers respond only in advanced type
// - counter bytes at A3/A4 only while halted
// - select high floats data, address, control ports
// - advanced keeps ports; standard floats port 0
// - port 2 mask bit one floats that pin
// - float mask at A5, reset FF, standard only
// - entry latches opcode undecoded, counter plus one
// - instruction latch cleared to no-op before exit
// - request low releases; resume at second phase
// - four states fetch; flag low end fourth phase
// - no halt entry while powered down
// - idle breakpoint: flag after wake service routine
// - page register on address high; aux port driven
// - bank bit7 picks control function; low nibble bank
// - idle strobes one, power-down zero, data floats
// - advanced idle: control zero or chip-select decode
// - request sampled end of first phase, flag rises
//
// Block notes:
// - every emulator pin passes a two-stage synchroniser, so the emulator sees
//   each strobe take effect about three clocks after it moves; address and
//   data must stay put for a few clocks on both sides of a strobe edge
// - the rest of the core (ALU, timers, port logic) sits outside; this block
//   owns the halt state, the emulation-visible registers and pin permissions
// - the phase strobes come from the core's state sequencer on this clock
// - power-on reset is the only reset; a halt clears nothing here but the instruction latch, set to the no-op before exit
// - halted_flag is registered, the pin permissions are combinational
module ehap_core #(
   parameter RAM_DEPTH = 256 // scratchpad size in bytes
)(
   input wire sys_clk,
   input wire resetn, // synchronous power-on reset, active low
   input wire advanced_type, // strap: advanced type when high
   input wire halt_request, // pin from emulator
   input wire space_select, // pin: low internal, high external
   input wire [7:0] emu_data_bus_in,
   output reg [7:0] emu_data_bus_out,
   output wire emu_data_bus_oe,
   input wire [7:0] emu_addr_low_in,
   output reg [7:0] emu_addr_low_out,
   output wire emu_addr_low_oe,
   input wire [7:0] emu_addr_high_port_in,
   output reg [7:0] emu_addr_high_port_out,
   output wire emu_addr_high_port_oe,
   input wire [7:0] emu_ctrl_port_in,
   output reg [7:0] emu_ctrl_port_out,
   output wire emu_ctrl_port_oe,
   output wire [7:0] port0_oe_allow, // per-pin permission for port 0 drivers
   output wire [7:0] port2_oe_allow, // per-pin permission for port 2 drivers
   output wire [7:0] aux_port_pins, // auxiliary port output
   output reg halted_flag, // emulation mode indicator
   output wire core_clk_en, // internal clock gate for the rest of the core
   input wire phase_s1_end, // core strobe: end of first state phase
   input wire phase_s4_end, // core strobe: end of fourth state phase
   input wire [7:0] fetch_opcode, // opcode at the breakpoint address
   input wire [15:0] core_addr, // core's current external address
   input wire indirect_xmove, // core running a register-pointer data move
   input wire far_data_move, // core running a far table or data move
   input wire idle_mode, // core in idle
   input wire power_down, // core in power-down
   input wire wake_isr_done, // pulse: wake interrupt service routine ended
   output reg [7:0] instr_latch, // instruction register seen by the core
   output reg [15:0] prog_counter, // program counter for the core
   output reg ale_out,
   output reg program_store_strobe
);

   // halt state machine, one-hot
   // RUN: core clocks free; HALT: frozen, emulator access open
   // EXIT: fetching the ignored second byte of the no-op
   // IDLEBP: breakpoint hit in idle, waiting for the wake service to finish
   localparam ST_RUN = 4'b0001;
   localparam ST_HALT = 4'b0010;
   localparam ST_EXIT = 4'b0100;
   localparam ST_IDLEBP = 4'b1000;
   reg [3:0] state_r; // current state
   reg [3:0] state_nxt;
   reg [2:0] exit_cnt_r; // states elapsed since resume

   // pin synchronisers: first stage feeds only the second
   // none are reset: the power-on reset holds long enough to flush them
   reg halt_s1_r, halt_s2_r;
   reg sel_s1_r, sel_s2_r;
   reg [7:0] dat_s1_r, dat_s2_r;
   reg [7:0] al_s1_r, al_s2_r;
   reg [7:0] ah_s1_r, ah_s2_r;
   reg [1:0] ct_s1_r, ct_s2_r;
   reg wr_prev_r; // write strobe delayed, for rising edge

   // registers
   // emulation-visible copies; reset values are the power-on values
   reg [7:0] ext_page_high_byte_r;
   reg [7:0] ext_bank_select_r;
   reg [7:0] port2_float_mask_r;
   reg [7:0] aux_port_output_r;
   reg [7:0] extra_irq_ctrl_status_r;
   reg [7:0] scratch_ram [0:RAM_DEPTH-1]; // scratchpad storage

   // decoded views of the state and of the synchronised strobes
   wire halted = state_r[1]; // ST_HALT
   wire internal_acc = halted & ~sel_s2_r;
   wire ram_space = ah_s2_r[0];
   wire rd_active = internal_acc & ~ct_s2_r[`EHAP_CTRL_RD_BIT];
   wire wr_rise = internal_acc & ct_s2_r[`EHAP_CTRL_WR_BIT] & ~wr_prev_r;

   // which special register addresses are live; used by read and write paths
   // absent registers ignore writes and read as zero, so a wrong-type probe is harmless
   function reg_present;
      input [7:0] a;
      input adv;
      begin
         case (a)
            `EHAP_ADDR_PAGE, `EHAP_ADDR_BANK, `EHAP_ADDR_AUX, `EHAP_ADDR_XIRQ: reg_present = adv;
            `EHAP_ADDR_PCL, `EHAP_ADDR_PCH: reg_present = 1'b1;
            `EHAP_ADDR_P2MASK: reg_present = ~adv;
            default: reg_present = 1'b0;
         endcase
      end
   endfunction
   wire sfr_wr = wr_rise & ~ram_space & reg_present(al_s2_r, advanced_type);

   // synchronise emulator pins
   // data and address pass two stages too; they are used only while the emulator
   // holds them steady, so multi-bit skew settles before any strobe edge is seen
   always @(posedge sys_clk)
   begin
      halt_s1_r <= halt_request;
      halt_s2_r <= halt_s1_r;
      sel_s1_r <= space_select;
      sel_s2_r <= sel_s1_r;
      dat_s1_r <= emu_data_bus_in;
      dat_s2_r <= dat_s1_r;
      al_s1_r <= emu_addr_low_in;
      al_s2_r <= al_s1_r;
      ah_s1_r <= emu_addr_high_port_in;
      ah_s2_r <= ah_s1_r;
      ct_s1_r <= emu_ctrl_port_in[1:0];
      ct_s2_r <= ct_s1_r;
   end

   // next-state logic
   // a request still high after exit re-enters at the next first-phase strobe
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
            // sampled at first phase end; power-down blocks entry
            if (halt_s2_r & phase_s1_end & ~power_down)
            begin
               if (idle_mode)
                  state_nxt = ST_IDLEBP;
               else
                  state_nxt = ST_HALT;
            end
         ST_IDLEBP:
            if (wake_isr_done)
               state_nxt = ST_HALT;
         ST_HALT:
            if (~halt_s2_r)
               state_nxt = ST_EXIT;
         ST_EXIT:
            if (phase_s4_end && exit_cnt_r == `EHAP_EXIT_STATES - 1)
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   // state, flag, latch and counter
   // entry, exit and counting are mutually exclusive, so the if chain hides no priority
   // counter writes come from the emulator only while halted, never on an entry edge
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_r <= ST_RUN;
         exit_cnt_r <= 3'd0;
         halted_flag <= 1'b0;
         instr_latch <= `EHAP_NOP_OPCODE;
         prog_counter <= {`EHAP_RST_PC, `EHAP_RST_PC};
         wr_prev_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         wr_prev_r <= ct_s2_r[`EHAP_CTRL_WR_BIT];
         if (state_r[0] && state_nxt[1])
         begin
            halted_flag <= 1'b1;
            instr_latch <= fetch_opcode; // undecoded capture
            prog_counter <= prog_counter + 16'h0001;
         end
         else if (state_r[3] && state_nxt[1])
         begin
            halted_flag <= 1'b1; // after wake service
            instr_latch <= fetch_opcode;
            prog_counter <= prog_counter + 16'h0001;
         end
         else if (halted && state_nxt[2])
         begin
            instr_latch <= `EHAP_NOP_OPCODE; // stale opcode never runs
            exit_cnt_r <= 3'd0;
         end
         else if (state_r[2] && phase_s4_end)
         begin
            exit_cnt_r <= exit_cnt_r + 3'd1;
            if (state_nxt[0])
               halted_flag <= 1'b0; // end of fourth phase
         end
         // counter writes while halted; emulator handles minus-one restart
         if (sfr_wr && al_s2_r == `EHAP_ADDR_PCL)
            prog_counter[7:0] <= dat_s2_r;
         if (sfr_wr && al_s2_r == `EHAP_ADDR_PCH)
            prog_counter[15:8] <= dat_s2_r;
      end
   end

   // special registers: emulator writes only; the core's own writes are outside this block
   // reserved bank bits are forced high on write so a read-back always shows them set
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         ext_page_high_byte_r <= `EHAP_RST_PAGE;
         ext_bank_select_r <= `EHAP_RST_BANK;
         port2_float_mask_r <= `EHAP_RST_P2MASK; // power-on only
         aux_port_output_r <= `EHAP_RST_AUX;
         extra_irq_ctrl_status_r <= `EHAP_RST_XIRQ;
      end
      else if (sfr_wr)
      begin
         case (al_s2_r)
            `EHAP_ADDR_PAGE: ext_page_high_byte_r <= dat_s2_r;
            `EHAP_ADDR_BANK: ext_bank_select_r <= dat_s2_r | `EHAP_BANK_RSVD; // reserved read as ones
            `EHAP_ADDR_P2MASK: port2_float_mask_r <= dat_s2_r;
            `EHAP_ADDR_AUX: aux_port_output_r <= dat_s2_r;
            `EHAP_ADDR_XIRQ: extra_irq_ctrl_status_r <= dat_s2_r;
            default: ext_page_high_byte_r <= ext_page_high_byte_r;
         endcase
      end
   end

   // scratchpad: only written by the emulator here, so halt leaves it intact
   // no reset on the array: it behaves as plain memory and keeps its contents
   always @(posedge sys_clk)
   begin
      if (wr_rise && ram_space)
         scratch_ram[al_s2_r] <= dat_s2_r;
   end

   // read data register for the data bus
   // refreshed every cycle while the read strobe is low, so a read that outlasts
   // the synchroniser delay always returns the current contents
   always @(posedge sys_clk)
   begin
      if (!resetn)
         emu_data_bus_out <= 8'h00;
      else if (rd_active)
      begin
         if (ram_space)
            emu_data_bus_out <= scratch_ram[al_s2_r];
         else if (!reg_present(al_s2_r, advanced_type))
            emu_data_bus_out <= 8'h00; // unmapped reads as zero
         else
            case (al_s2_r)
               `EHAP_ADDR_PAGE: emu_data_bus_out <= ext_page_high_byte_r;
               `EHAP_ADDR_BANK: emu_data_bus_out <= ext_bank_select_r;
               `EHAP_ADDR_PCL: emu_data_bus_out <= prog_counter[7:0];
               `EHAP_ADDR_PCH: emu_data_bus_out <= prog_counter[15:8];
               `EHAP_ADDR_P2MASK: emu_data_bus_out <= port2_float_mask_r;
               `EHAP_ADDR_AUX: emu_data_bus_out <= aux_port_output_r;
               default: emu_data_bus_out <= extra_irq_ctrl_status_r;
            endcase
      end
   end

   // address and control outputs while running; frozen when halted
   // the idle and power-down strobe levels are held after the core wakes, until the next idle or power-down
   // chip-select decode has priority over the bank nibble when bank bit 7 is set
   always @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         emu_addr_low_out <= 8'h00;
         emu_addr_high_port_out <= 8'h00;
         emu_ctrl_port_out <= 8'h00;
         ale_out <= 1'b1;
         program_store_strobe <= 1'b1;
      end
      else if (!halted) // pins hold prior state while halted
      begin
         emu_addr_low_out <= core_addr[7:0];
         if (indirect_xmove)
            emu_addr_high_port_out <= ext_page_high_byte_r;
         else
            emu_addr_high_port_out <= core_addr[15:8];
         if (advanced_type && ext_bank_select_r[`EHAP_BANK_FUNC_BIT])
            emu_ctrl_port_out <= {4'h0, ~(4'h1 << core_addr[15:14])}; // chip selects
         else if (advanced_type && far_data_move && !idle_mode && !power_down)
            emu_ctrl_port_out <= {4'h0, ext_bank_select_r[3:0]};
         else
            emu_ctrl_port_out <= 8'h00;
         if (power_down)
         begin
            ale_out <= 1'b0;
            program_store_strobe <= 1'b0;
         end
         else if (idle_mode)
         begin
            ale_out <= 1'b1;
            program_store_strobe <= 1'b1;
         end
      end
   end

   // clocks stop only while halted; in the idle breakpoint wait the core must
   // keep running so that its wake service routine can finish
   assign core_clk_en = ~halted;

   // internal-access bus drives only on read; select high floats all
   // the address and control ports are inputs during internal access, so they
   // float in both halted spaces; driving them would fight the emulator
   assign emu_data_bus_oe = halted ? rd_active : ~(idle_mode | power_down);
   assign emu_addr_low_oe = ~(halted & sel_s2_r) & ~internal_acc;
   assign emu_addr_high_port_oe = ~(halted & sel_s2_r) & ~internal_acc;
   assign emu_ctrl_port_oe = ~(halted & sel_s2_r) & ~internal_acc;

   // port floating for external access
   // the standard type relies on the emulator loading the mask first
   assign port0_oe_allow = (halted & sel_s2_r & ~advanced_type) ? 8'h00 : 8'hFF;
   assign port2_oe_allow = (halted & sel_s2_r & ~advanced_type) ? ~port2_float_mask_r : 8'hFF;
   assign aux_port_pins = aux_port_output_r;
endmodule

// [ehap_map.vh]
// register offsets, reset values and bit positions for the emulation halt and access port
`ifndef EHAP_MAP_VH
`define EHAP_MAP_VH
`define EHAP_ADDR_PAGE 8'hA1
`define EHAP_ADDR_BANK 8'hA2
`define EHAP_ADDR_PCL 8'hA3
`define EHAP_ADDR_PCH 8'hA4
`define EHAP_ADDR_P2MASK 8'hA5
`define EHAP_ADDR_AUX 8'hA6
`define EHAP_ADDR_XIRQ 8'hC0
`define EHAP_RST_PAGE 8'h00
`define EHAP_RST_BANK 8'h70
`define EHAP_RST_PC 8'h00
`define EHAP_RST_P2MASK 8'hFF
`define EHAP_RST_AUX 8'hFF
`define EHAP_RST_XIRQ 8'h00
`define EHAP_BANK_RSVD 8'h70
`define EHAP_BANK_FUNC_BIT 7
`define EHAP_CTRL_WR_BIT 0
`define EHAP_CTRL_RD_BIT 1
`define EHAP_NOP_OPCODE 8'h00
`define EHAP_EXIT_STATES 4
`endif

// [ehap_asserts.sv]
// checker: entry, exit, freeze and floating relations at the core ports
`timescale 1ns/10ps
module ehap_asserts (
   input wire sys_clk,
   input wire resetn,
   input wire advanced_type,
   input wire space_select,
   input wire [7:0] emu_ctrl_port_in,
   input wire emu_data_bus_oe,
   input wire emu_addr_low_oe,
   input wire emu_addr_high_port_oe,
   input wire emu_ctrl_port_oe,
   input wire [7:0] port0_oe_allow,
   input wire halted_flag,
   input wire core_clk_en,
   input wire phase_s1_end,
   input wire phase_s4_end,
   input wire [7:0] fetch_opcode,
   input wire idle_mode,
   input wire power_down,
   input wire [7:0] instr_latch,
   input wire [15:0] prog_counter,
   input wire ale_out,
   input wire program_store_strobe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // three samples outlast the two-stage pin synchroniser
   sequence s_ext;
      (space_select && halted_flag)[*3];
   endsequence
   sequence s_entry;
      $rose(halted_flag) && !$past(idle_mode);
   endsequence
   property p_entry; s_entry |-> $past(phase_s1_end) && !core_clk_en; endproperty
   a_entry: assert property (p_entry) else $error("halt entry off phase");
   property p_latch; s_entry |-> instr_latch == $past(fetch_opcode) && prog_counter == $past(prog_counter) + 16'h0001;
   endproperty
   a_latch: assert property (p_latch) else $error("entry latch or counter wrong");
   property p_frozen; !core_clk_en && !$past(core_clk_en) |-> $stable(ale_out) && $stable(program_store_strobe);
   endproperty
   a_frozen: assert property (p_frozen) else $error("strobes moved while halted");
   property p_float; s_ext |-> !(emu_data_bus_oe | emu_addr_low_oe | emu_addr_high_port_oe | emu_ctrl_port_oe);
   endproperty
   a_float: assert property (p_float) else $error("emulator port driven in external space");
   property p_port0; s_ext |-> port0_oe_allow == (advanced_type ? 8'hff : 8'h00); endproperty
   a_port0: assert property (p_port0) else $error("port 0 permission wrong");
   property p_exit; $fell(halted_flag) |-> $past(phase_s4_end) && instr_latch == 8'h00; endproperty
   a_exit: assert property (p_exit) else $error("flag fell off phase or latch not cleared");
   property p_pd; !halted_flag && power_down |=> !halted_flag; endproperty
   a_pd: assert property (p_pd) else $error("halt entered in power-down");
   // while halted the data bus drives only in answer to the read strobe
   property p_rd; !core_clk_en && emu_data_bus_oe |-> !$past(emu_ctrl_port_in[1], 2); endproperty
   a_rd: assert property (p_rd) else $error("data bus driven without read strobe");
endmodule

// [ehap_emu_model.sv]
// emulator-side model: halt pin, space select and internal access cycles
`timescale 1ns/10ps
module ehap_emu_model (
   input wire sys_clk,
   input wire [7:0] dev_data,
   input wire dev_data_oe,
   output reg halt_request,
   output reg space_select,
   output wire [7:0] data_bus,
   output reg [7:0] addr_low,
   output reg [7:0] addr_high,
   output reg [7:0] ctrl
);
   reg [7:0] drv_r; // write data
   reg drv_en_r; // high while the model drives
   reg [7:0] last_r; // wire level one cycle back
   // a released wire toggles so a stale value never looks valid
   assign data_bus = dev_data_oe ? dev_data : (drv_en_r ? drv_r : ~last_r);
   always @(posedge sys_clk) last_r <= data_bus;
   initial
   begin
      {halt_request, space_select, drv_en_r} = 3'h0;
      {addr_low, addr_high, drv_r, last_r} = 32'h0000_0000;
      ctrl = 8'hff;
   end
   task step(input integer n);
   begin
      repeat (n) @(posedge sys_clk);
      #1;
   end
   endtask
   task pins(input h, input s);
   begin
      halt_request = h;
      space_select = s;
      step(1);
   end
   endtask
   // address and data held well past the strobe rise
   task wr(input [8:0] a, input [7:0] d);
   begin
      addr_low = a[7:0];
      addr_high = {7'h00, a[8]};
      drv_r = d;
      drv_en_r = 1'b1;
      step(1);
      ctrl[0] = 1'b0;
      step(3);
      ctrl[0] = 1'b1;
      step(5);
      drv_en_r = 1'b0;
   end
   endtask
   task rd(input [8:0] a, output [7:0] d);
   begin
      addr_low = a[7:0];
      addr_high = {7'h00, a[8]};
      step(1);
      ctrl[1] = 1'b0;
      step(5);
      d = data_bus;
      ctrl[1] = 1'b1;
      step(3);
   end
   endtask
endmodule

// [testbench.sv]
// testbench: halt entry and exit, register access, floating for both types
`timescale 1ns/10ps
module testbench;
   reg sys_clk, resetn, advanced_type, power_down;
   reg [7:0] fetch_opcode;
   reg [1:0] ph_r = 2'h0; // stands in for the core state phases
   reg [15:0] core_addr; // core's external address
   reg ixm, fdm, idle, wake; // core move, idle and wake status
   integer n_errors, total_checks, cyc;
   wire [7:0] dq, dq_out, al, ah, ct, p0, p2, aux, il, al_o, ah_o, ct_o;
   wire [15:0] pc;
   wire hr, ss, dq_oe, flag, clk_en, al_oe, ah_oe, ct_oe, ale, pss;
   ehap_emu_model emu (.sys_clk(sys_clk), .dev_data(dq_out), .dev_data_oe(dq_oe), .halt_request(hr),
      .space_select(ss), .data_bus(dq), .addr_low(al), .addr_high(ah), .ctrl(ct));
   ehap_core uut (.sys_clk(sys_clk), .resetn(resetn), .advanced_type(advanced_type), .halt_request(hr),
      .space_select(ss), .emu_data_bus_in(dq), .emu_data_bus_out(dq_out), .emu_data_bus_oe(dq_oe),
      .emu_addr_low_in(al), .emu_addr_low_out(al_o), .emu_addr_low_oe(al_oe), .emu_addr_high_port_in(ah),
      .emu_addr_high_port_out(ah_o), .emu_addr_high_port_oe(ah_oe), .emu_ctrl_port_in(ct), .emu_ctrl_port_out(ct_o),
      .emu_ctrl_port_oe(ct_oe), .port0_oe_allow(p0), .port2_oe_allow(p2), .aux_port_pins(aux), .halted_flag(flag),
      .core_clk_en(clk_en), .phase_s1_end(ph_r == 2'd0), .phase_s4_end(ph_r == 2'd3), .fetch_opcode(fetch_opcode),
      .core_addr(core_addr), .indirect_xmove(ixm), .far_data_move(fdm), .idle_mode(idle),
      .power_down(power_down), .wake_isr_done(wake), .instr_latch(il), .prog_counter(pc), .ale_out(ale),
      .program_store_strobe(pss));
   initial
   begin
      sys_clk = 0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) ph_r <= #1 ph_r + 2'd1;
   // hang guard
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         end_of_test;
      end
   end
   task chk(input string nm, input [15:0] e, input [15:0] g);
   begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task rc(input string nm, input [8:0] a, input [7:0] e);
      reg [7:0] d;
   begin
      emu.rd(a, d);
      chk(nm, e, d);
   end
   endtask
   task do_reset(input adv);
   begin
      resetn = 0;
      advanced_type = adv;
      emu.pins(0, 0);
      repeat (6) @(posedge sys_clk);
      #1 resetn = 1;
      chk("rst latch", 8'h00, il);
      chk("rst pc", 16'h0000, pc);
      chk("rst aux", 8'hff, aux);
   end
   endtask
   task enter(input [7:0] opc, input [15:0] epc);
      integer k;
   begin
      fetch_opcode = opc;
      emu.pins(1, 0);
      for (k = 0; k < 40 && flag !== 1'b1; k = k + 1) emu.step(1);
      chk("flag", 1'b1, flag);
      chk("latch", opc, il);
      chk("pc", epc, pc);
      chk("al_oe", 1'b0, al_oe);
      chk("clk_en", 1'b0, clk_en);
   end
   endtask
   // external space: ports floated per type and mask
   task ext(input [7:0] e0, input [7:0] e2);
   begin
      emu.pins(1, 1);
      emu.step(4);
      chk("dq_oe", 1'b0, dq_oe);
      chk("port oe", 3'h0, {al_oe, ah_oe, ct_oe});
      chk("p0", e0, p0);
      chk("p2", e2, p2);
      emu.pins(1, 0);
      emu.step(3);
   end
   endtask
   task leave;
      integer k;
   begin
      emu.pins(0, 0);
      for (k = 0; k < 60 && flag !== 1'b0; k = k + 1) emu.step(1);
      chk("flag", 1'b0, flag);
      chk("exit long", 1'b1, k >= 12);
      chk("latch", 8'h00, il);
      chk("clk_en", 1'b1, clk_en);
   end
   endtask
   task t_std;
   begin
      do_reset(0);
      enter(8'h74, 16'h0001);
      rc("mask", 9'h0a5, 8'hff);
      rc("page", 9'h0a1, 8'h00);
      emu.wr(9'h1a5, 8'h3c);
      rc("ram", 9'h1a5, 8'h3c);
      rc("mask", 9'h0a5, 8'hff);
      rc("pcl", 9'h0a3, 8'h01);
      emu.wr(9'h0a3, 8'h00);
      emu.wr(9'h0a4, 8'h12);
      chk("pc", 16'h1200, pc);
      emu.wr(9'h0a5, 8'h3f);
      rc("mask", 9'h0a5, 8'h3f);
      ext(8'h00, 8'hc0);
      leave;
   end
   endtask
   task t_adv;
   begin
      do_reset(1);
      enter(8'he5, 16'h0001);
      core_addr = 16'h4321;
      emu.step(2);
      chk("frozen al", 8'h00, al_o);
      emu.wr(9'h0a6, 8'h5a);
      chk("aux", 8'h5a, aux);
      rc("bank", 9'h0a2, 8'h70);
      emu.wr(9'h0a2, 8'h05);
      rc("bank", 9'h0a2, 8'h75);
      emu.wr(9'h0a1, 8'h9c);
      rc("page", 9'h0a1, 8'h9c);
      rc("mask", 9'h0a5, 8'h00);
      emu.wr(9'h0c0, 8'h0c);
      rc("xirq", 9'h0c0, 8'h0c);
      ext(8'hff, 8'hff);
      leave;
      emu.step(2);
      chk("al out", 8'h21, al_o);
      chk("ah out", 8'h43, ah_o);
      chk("ctrl out", 8'h00, ct_o);
      {ixm, fdm} = 2'h3;
      emu.step(2);
      chk("page out", 8'h9c, ah_o);
      chk("bank out", 8'h05, ct_o);
      {ixm, fdm} = 2'h0;
      power_down = 1;
      emu.pins(1, 0);
      emu.step(20);
      chk("pd flag", 1'b0, flag);
      chk("pd strobes", 2'h0, {ale, pss});
      chk("pd ctrl", 8'h00, ct_o);
      chk("pd dq_oe", 1'b0, dq_oe);
      emu.pins(0, 0);
      emu.step(2);
      power_down = 0;
   end
   endtask
   // chip-select decode, idle strobes and a breakpoint right after idle entry
   task t_cs;
   begin
      do_reset(1);
      enter(8'h12, 16'h0001);
      emu.wr(9'h0a2, 8'h80);
      rc("bank", 9'h0a2, 8'hf0);
      leave;
      core_addr = 16'hc000;
      power_down = 1;
      emu.step(2);
      chk("pd cs", 8'h07, ct_o);
      power_down = 0;
      idle = 1;
      emu.step(2);
      chk("cs decode", 8'h07, ct_o);
      chk("idle strobes", 2'h3, {ale, pss});
      chk("idle dq_oe", 1'b0, dq_oe);
      emu.pins(1, 0);
      emu.step(12);
      chk("idle flag", 1'b0, flag);
      chk("idle clk_en", 1'b1, clk_en);
      wake = 1;
      emu.step(1);
      {wake, idle} = 2'h0;
      chk("wake flag", 1'b1, flag);
      chk("wake pc", 16'h0002, pc);
      leave;
   end
   endtask
   task end_of_test;
   begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      {n_errors, total_checks, cyc} = 0;
      {resetn, advanced_type, power_down, fetch_opcode} = 0;
      {core_addr, ixm, fdm, idle, wake} = 0;
      t_std;
      t_adv;
      t_cs;
      end_of_test;
   end
endmodule
bind ehap_core ehap_asserts chk (.*);
